// ---- logic/rtc_pkg.sv ----
// constants shared by the host controller for the battery-backed clock SRAM
package rtc_pkg;

  // byte-wide memory pins
  localparam int unsigned MEM_AW = 11;
  localparam int unsigned MEM_DW = 8;
  // clock bytes sit at the top eight addresses; the lowest one is control
  localparam logic [10:0] CLK_BASE = 11'h7f8;
  localparam logic [10:0] CLK_CTRL_ADDR = 11'h7f8;

  // axi4-lite slave side
  localparam int unsigned AXI_AW = 8;
  localparam logic [7:0] REG_ADDR_OFS = 8'h00;
  localparam logic [7:0] REG_WDAT_OFS = 8'h04;
  localparam logic [7:0] REG_CMD_OFS = 8'h08;
  localparam logic [7:0] REG_STAT_OFS = 8'h0c;
  localparam logic [7:0] REG_RDAT_OFS = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // command and status fields
  localparam int unsigned CMD_RD_BIT = 0;
  localparam int unsigned CMD_WR_BIT = 1;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_DONE_BIT = 1;
  localparam int unsigned ST_READY_BIT = 2;
  localparam int unsigned ST_REFUSED_BIT = 3;
  localparam int unsigned ST_PWR_BIT = 4;
  localparam int unsigned ST_CLKAREA_BIT = 5;
  localparam logic [10:0] ADDR_RST = 11'h000;
  localparam logic [7:0] WDAT_RST = 8'h00;

  // timing, clock period and strobe figures
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned T_WSTB_NS = 75;
  localparam int unsigned T_RACC_NS = 120;
  localparam int unsigned T_HOLD_NS = 10;
  localparam int unsigned T_REC_MS = 2;
  localparam int unsigned W_STB_CYC = (T_WSTB_NS + CLK_NS - 1) / CLK_NS;
  // one extra cycle so the sampled byte has settled at the pins
  localparam int unsigned R_STB_CYC = (T_RACC_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int unsigned HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned REC_CYC_DEF = (T_REC_MS * 1000000) / CLK_NS;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned REC_W = 20;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SETUP = 2'b01,
    S_STROBE = 2'b10,
    S_HOLD = 2'b11
  } rtc_seq_e;

endpackage : rtc_pkg

// ---- logic/rtc_cmd_if.sv ----
// command carrier between the register front end and the pin sequencer
`timescale 1ns/1ps
`default_nettype none
interface rtc_cmd_if;
  logic req;
  logic wr;
  logic abort;
  logic [10:0] addr;
  logic [7:0] wdata;
  logic busy;
  logic done;
  logic [7:0] rdata;
  modport master (output req, wr, abort, addr, wdata, input busy, done, rdata);
  modport seq (input req, wr, abort, addr, wdata, output busy, done, rdata);
endinterface : rtc_cmd_if
`default_nettype wire

// ---- logic/rtc_pin_seq.sv ----
// pin sequencer: one asynchronous-strobe read or write cycle per request
`timescale 1ns/1ps
`default_nettype none
module rtc_pin_seq
  import rtc_pkg::*;
#(
  parameter int unsigned P_W_STB = W_STB_CYC,
  parameter int unsigned P_R_STB = R_STB_CYC,
  parameter int unsigned P_HOLD = HOLD_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // command side
  rtc_cmd_if.seq cmd,
  // memory pins
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe_o,
  output logic [10:0] addr_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o
);

  if (P_W_STB < 1 || P_W_STB > 2**CNT_W || P_R_STB < 1 || P_R_STB > 2**CNT_W ||
      P_HOLD < 1 || P_HOLD > 2**CNT_W) begin : g_chk
    $error("strobe counts out of range");
  end

  rtc_seq_e state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, stb_last, hold_last;
  logic wr_r, wr_nxt, ce_n_r, oe_n_r, we_n_r, dq_oe_r, done_r;
  logic [10:0] addr_r;
  logic [7:0] wdat_r, rdat_r;
  wire accept = (state_r == S_IDLE) && cmd.req && !cmd.abort;
  wire strobe_end = (state_r == S_STROBE) && (cnt_r == stb_last) && !cmd.abort;
  wire hold_end = (state_r == S_HOLD) && (cnt_r == hold_last) && !cmd.abort;

  assign stb_last = wr_r ? CNT_W'(P_W_STB - 1) : CNT_W'(P_R_STB - 1);
  assign hold_last = CNT_W'(P_HOLD - 1);
  assign wr_nxt = accept ? cmd.wr : wr_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      S_IDLE: begin
        if (accept) begin
          state_nxt = S_SETUP;
        end
      end
      S_SETUP: begin
        state_nxt = S_STROBE;
        cnt_nxt = '0;
      end
      S_STROBE: begin
        if (cnt_r == stb_last) begin
          state_nxt = S_HOLD;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      S_HOLD: begin
        if (cnt_r == hold_last) begin
          state_nxt = S_IDLE;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
    // losing supply ends the cycle at once, strobes return high
    if (cmd.abort) begin
      state_nxt = S_IDLE;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= S_IDLE;
      cnt_r <= '0;
      wr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
    end
  end

  // chip enable and write enable fall and rise together: one clean write window
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ce_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      dq_oe_r <= 1'b0;
    end else begin
      ce_n_r <= !(state_nxt == S_STROBE);
      we_n_r <= !(state_nxt == S_STROBE && wr_nxt);
      oe_n_r <= !(state_nxt == S_STROBE && !wr_nxt);
      dq_oe_r <= wr_nxt && (state_nxt != S_IDLE);
    end
  end

  // same cycle shape for clock bytes and plain bytes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_r <= '0;
      wdat_r <= '0;
    end else if (accept) begin
      addr_r <= cmd.addr;
      wdat_r <= cmd.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdat_r <= '0;
      done_r <= 1'b0;
    end else begin
      if (strobe_end && !wr_r) begin
        rdat_r <= dq_i;
      end
      done_r <= hold_end;
    end
  end

  assign cmd.busy = (state_r != S_IDLE);
  assign cmd.done = done_r;
  assign cmd.rdata = rdat_r;
  assign dq_o = wdat_r;
  assign dq_oe_o = dq_oe_r;
  assign addr_o = addr_r;
  assign ce_n_o = ce_n_r;
  assign oe_n_o = oe_n_r;
  assign we_n_o = we_n_r;

  wr_edge_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $fell(we_n_r) |-> $fell(ce_n_r) && oe_n_r && dq_oe_r)
    else $error("write strobe did not open with chip enable");
  wr_end_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_r == S_STROBE && wr_r && cnt_r == stb_last && !cmd.abort) |=> we_n_r && ce_n_r)
    else $error("write strobe did not close with chip enable");
  rd_only_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !oe_n_r |-> we_n_r && !ce_n_r && !dq_oe_r)
    else $error("output enable low outside a read");
  wr_drive_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !we_n_r |-> dq_oe_r && oe_n_r)
    else $error("write strobe without driven data");
  rd_sample_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (strobe_end && !wr_r) |=> rdat_r == $past(dq_i) ##[1:8] (done_r || cmd.abort))
    else $error("read byte not captured or done missing");
  cv_write_c: cover property (@(posedge clk_i) disable iff (!arst_n_i) done_r && wr_r);
  cv_read_c: cover property (@(posedge clk_i) disable iff (!arst_n_i) done_r && !wr_r);
  cv_abort_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_r == S_STROBE) && cmd.abort);

endmodule : rtc_pin_seq
`default_nettype wire

// ---- logic/rtc_host_ctrl.sv ----
// host controller: axi4-lite registers driving a battery-backed clock SRAM
// Operation
// - clock bytes use the same read and write cycles as plain memory
// - host deasserts chip or write enable before supply falls, zero lead; the code raises both on the clock after PWR_ABOVE_THRESH_I falls
// - host holds strobes off for the recovery interval after power-up
// - host keeps chip enable high while the supply ramps past threshold
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rtc_host_ctrl
  import rtc_pkg::*;
#(
  parameter int unsigned P_REC_CYC = REC_CYC_DEF
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  // axi4-lite write address and data
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  // axi4-lite write response
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  output logic [1:0] S_AXI_BRESP_O,
  // axi4-lite read
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  input wire logic [7:0] S_AXI_ARADDR_I,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  // memory pins
  output logic [10:0] BYTE_ADDR_O,
  input wire logic [7:0] BYTE_LINES_I,
  output logic [7:0] BYTE_LINES_O,
  output logic BYTE_LINES_OE_O,
  output logic CE_N_O,
  output logic OE_N_O,
  output logic WE_N_O,
  // supply monitor, high while above the power-fail threshold
  input wire logic PWR_ABOVE_THRESH_I
);

  if (P_REC_CYC < 1 || P_REC_CYC >= 2**REC_W) begin : g_chk
    $error("recovery count out of range");
  end

  rtc_cmd_if cmd_if ();

  logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [10:0] addr_r;
  logic [7:0] wdat_r;
  logic req_r, cmd_wr_r, done_r, refused_r;
  logic [REC_W-1:0] rec_cnt_r;

  // write side decode
  wire wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  wire sel_addr = (awaddr_r == REG_ADDR_OFS);
  wire sel_wdat = (awaddr_r == REG_WDAT_OFS);
  wire sel_cmd = (awaddr_r == REG_CMD_OFS);
  wire sel_stat = (awaddr_r == REG_STAT_OFS);
  wire w_hit = sel_addr || sel_wdat || sel_cmd || sel_stat || (awaddr_r == REG_RDAT_OFS);
  wire cmd_rd = wdata_r[CMD_RD_BIT];
  wire cmd_wr = wdata_r[CMD_WR_BIT];
  wire cmd_go = wr_fire && sel_cmd && wstrb_r[0] && (cmd_rd || cmd_wr);
  // recovery gate: strobes stay off until supply has been good for the full hold
  wire rec_full = (rec_cnt_r == REC_W'(P_REC_CYC));
  wire ready_w = rec_full && PWR_ABOVE_THRESH_I;
  wire busy_all = req_r || cmd_if.busy;
  wire cmd_ok = cmd_go && ready_w && !busy_all && (cmd_rd != cmd_wr);
  wire refuse_set = cmd_go && !cmd_ok;
  wire clr_done = wr_fire && sel_stat && wstrb_r[0] && wdata_r[ST_DONE_BIT];
  wire clr_ref = wr_fire && sel_stat && wstrb_r[0] && wdata_r[ST_REFUSED_BIT];
  wire clk_area = (addr_r >= CLK_BASE);
  wire [7:0] status_w = {2'h0, clk_area, PWR_ABOVE_THRESH_I, refused_r, ready_w, done_r,
                         busy_all};

  // read side decode
  wire ar_fire = S_AXI_ARVALID_I && !rvalid_r;
  wire [AXI_AW-1:0] ra = S_AXI_ARADDR_I;
  wire r_hit = (ra == REG_ADDR_OFS) || (ra == REG_WDAT_OFS) || (ra == REG_CMD_OFS) ||
               (ra == REG_STAT_OFS) || (ra == REG_RDAT_OFS);
  wire [31:0] rd_mux = (ra == REG_ADDR_OFS) ? {21'h0, addr_r} :
                       (ra == REG_WDAT_OFS) ? {24'h000000, wdat_r} :
                       (ra == REG_STAT_OFS) ? {24'h000000, status_w} :
                       (ra == REG_RDAT_OFS) ? {24'h000000, cmd_if.rdata} : 32'h00000000;

  assign S_AXI_AWREADY_O = !aw_hold_r && !bvalid_r;
  assign S_AXI_WREADY_O = !w_hold_r && !bvalid_r;
  assign S_AXI_BVALID_O = bvalid_r;
  assign S_AXI_BRESP_O = bresp_r;
  assign S_AXI_ARREADY_O = !rvalid_r;
  assign S_AXI_RVALID_O = rvalid_r;
  assign S_AXI_RDATA_O = rdata_r;
  assign S_AXI_RRESP_O = rresp_r;

  // address and data are taken in either order and held until the write completes
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= '0;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_hold_r <= 1'b1;
      awaddr_r <= S_AXI_AWADDR_I;
    end else if (wr_fire) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      w_hold_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_hold_r <= 1'b1;
      wdata_r <= S_AXI_WDATA_I;
      wstrb_r <= S_AXI_WSTRB_I;
    end else if (wr_fire) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= w_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= r_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      rvalid_r <= 1'b0;
    end
  end

  // target address and write byte, one lane per byte
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      addr_r <= ADDR_RST;
      wdat_r <= WDAT_RST;
    end else begin
      if (wr_fire && sel_addr && wstrb_r[0]) begin
        addr_r[7:0] <= wdata_r[7:0];
      end
      if (wr_fire && sel_addr && wstrb_r[1]) begin
        addr_r[10:8] <= wdata_r[10:8];
      end
      if (wr_fire && sel_wdat && wstrb_r[0]) begin
        wdat_r <= wdata_r[7:0];
      end
    end
  end

  // sticky flags: a setting event in the clearing cycle wins
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      req_r <= 1'b0;
      cmd_wr_r <= 1'b0;
      done_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      req_r <= cmd_ok;
      if (cmd_ok) begin
        cmd_wr_r <= cmd_wr;
      end
      done_r <= cmd_if.done || (done_r && !clr_done);
      refused_r <= refuse_set || (refused_r && !clr_ref);
    end
  end

  // counts only while supply is good; any dip restarts the whole hold
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rec_cnt_r <= '0;
    end else if (!PWR_ABOVE_THRESH_I) begin
      rec_cnt_r <= '0;
    end else if (!rec_full) begin
      rec_cnt_r <= rec_cnt_r + 1'b1;
    end
  end

  assign cmd_if.req = req_r;
  assign cmd_if.wr = cmd_wr_r;
  assign cmd_if.addr = addr_r;
  assign cmd_if.wdata = wdat_r;
  assign cmd_if.abort = !ready_w;

  rtc_pin_seq u_seq (
    .clk_i(CLK_SYS_I),
    .arst_n_i(ARST_N_I),
    .cmd(cmd_if),
    .dq_i(BYTE_LINES_I),
    .dq_o(BYTE_LINES_O),
    .dq_oe_o(BYTE_LINES_OE_O),
    .addr_o(BYTE_ADDR_O),
    .ce_n_o(CE_N_O),
    .oe_n_o(OE_N_O),
    .we_n_o(WE_N_O)
  );

  pd_deselect_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    !PWR_ABOVE_THRESH_I |=> CE_N_O && WE_N_O && !BYTE_LINES_OE_O && rec_cnt_r == '0)
    else $error("strobes active after supply loss");
  rec_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    !ready_w |=> CE_N_O && WE_N_O)
    else $error("strobes active inside recovery hold");
  rec_done_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    (PWR_ABOVE_THRESH_I && rec_cnt_r == REC_W'(P_REC_CYC - 1)) |=> rec_full)
    else $error("recovery hold did not end on count");
  refuse_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    refuse_set |=> refused_r && !req_r)
    else $error("refused command was started");
  start_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    cmd_ok |=> req_r ##2 (!CE_N_O || !ready_w))
    else $error("accepted command did not reach the pins");
  bresp_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    wr_fire |=> S_AXI_BVALID_O && !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write response missing");
  rresp_a: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    ar_fire |=> S_AXI_RVALID_O && S_AXI_RDATA_O == $past(rd_mux))
    else $error("read data mismatch");
  cv_refuse_c: cover property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I) refuse_set);
  cv_ready_c: cover property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I) $rose(ready_w));

endmodule : rtc_host_ctrl
`default_nettype wire

// ---- bench/rtc_dev_model.sv ----
// behavioural model of the battery-backed clock SRAM on the far side
`timescale 1ns/1ps
`default_nettype none
module rtc_dev_model #(
  parameter realtime P_REC_NS = 160.0
) (
  input wire logic [10:0] addr_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe_o,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic pwr_ok_i,
  input wire logic tick_i,
  output logic viol_o
);
  logic [7:0] mem [0:2047];
  logic [7:0] cnt_r;
  logic [7:0] last_r;
  realtime t_up;
  wire logic sel = pwr_ok_i && !ce_n_i;
  wire logic wr_act = sel && !we_n_i;
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 8'(i);
    end
    cnt_r = 8'h00;
    last_r = 8'h00;
    t_up = 0;
    viol_o = 1'b0;
  end
  // the byte lands at the earlier rising strobe; a supply drop first cancels it
  always @(negedge wr_act) begin
    if (pwr_ok_i) begin
      if (addr_i == 11'h7f8 && mem[11'h7f8][7] && !dq_i[7]) begin
        cnt_r = mem[11'h7f9];
      end
      mem[addr_i] = dq_i;
    end
  end
  assign dq_oe_o = sel && we_n_i && !oe_n_i;
  always @(*) begin
    if (dq_oe_o) begin
      last_r = mem[addr_i];
    end
  end
  // released lines show the inverse so a stale sample cannot pass
  assign dq_o = dq_oe_o ? mem[addr_i] : ~last_r;
  always @(posedge tick_i) begin
    if (cnt_r == 8'h59) begin
      cnt_r = 8'h00;
    end else if (cnt_r[3:0] == 4'h9) begin
      cnt_r = {cnt_r[7:4] + 4'h1, 4'h0};
    end else begin
      cnt_r = cnt_r + 8'h01;
    end
    if (mem[11'h7f8][7:6] == 2'b00) begin
      mem[11'h7f9] = cnt_r;
    end
  end
  always @(posedge pwr_ok_i) begin
    t_up = $realtime;
  end
  always @(negedge ce_n_i) begin
    if (!pwr_ok_i || $realtime - t_up < P_REC_NS) begin
      viol_o = 1'b1;
    end
  end
  always @(negedge pwr_ok_i) begin
    #20;
    if (!ce_n_i && !we_n_i) begin
      viol_o = 1'b1;
    end
  end
endmodule : rtc_dev_model
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the clock SRAM host controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rtc_pkg::*;
  localparam int unsigned REC = 20;
  localparam logic [31:0] RF = 32'h1 << ST_REFUSED_BIT;
  localparam logic [31:0] RY = 32'h1 << ST_READY_BIT;
  localparam logic [31:0] PW = 32'h1 << ST_PWR_BIT;
  localparam logic [31:0] CA = 32'h1 << ST_CLKAREA_BIT;
  typedef struct {
    logic [7:0] a;
    logic [31:0] w;
    logic [31:0] e;
    logic [1:0] r;
  } rtc_row_s;
  rtc_row_s rows [6] = '{
    '{REG_ADDR_OFS, 32'h0000_07ff, 32'h0000_07ff, RESP_OKAY},
    '{REG_ADDR_OFS, 32'h0000_fabc, 32'h0000_02bc, RESP_OKAY},
    '{REG_WDAT_OFS, 32'h1234_56a5, 32'h0000_00a5, RESP_OKAY},
    '{REG_CMD_OFS, 32'h0000_0003, 32'h0000_0000, RESP_OKAY},
    '{8'h14, 32'h0000_0055, 32'h0000_0000, RESP_SLVERR},
    '{8'hfc, 32'h0000_0055, 32'h0000_0000, RESP_SLVERR}
  };
  logic clk, rst_n, awv, wv, bre, arv, rre, pwr, tick;
  logic awr, wrdy, bv, arr, rv, oe_h, ce_n, oe_n, we_n, dev_oe, viol;
  logic [1:0] bresp, rresp, r;
  logic [7:0] awa, ara, bl_o, bl_i, dq_dev, q;
  logic [10:0] baddr;
  logic [31:0] wd, rdat, s;
  logic [3:0] ws;
  int fails, n_checks, cyc;
  assign bl_i = oe_h ? bl_o : dq_dev;
  rtc_host_ctrl #(.P_REC_CYC(REC)) rtc_host_ctrl_i (
    .CLK_SYS_I(clk), .ARST_N_I(rst_n),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws),
    .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre), .S_AXI_BRESP_O(bresp),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rresp),
    .BYTE_ADDR_O(baddr), .BYTE_LINES_I(bl_i), .BYTE_LINES_O(bl_o), .BYTE_LINES_OE_O(oe_h),
    .CE_N_O(ce_n), .OE_N_O(oe_n), .WE_N_O(we_n), .PWR_ABOVE_THRESH_I(pwr)
  );
  rtc_dev_model #(.P_REC_NS(REC * 8.0)) rtc_dev_model_i (
    .addr_i(baddr), .dq_i(bl_i), .dq_o(dq_dev), .dq_oe_o(dev_oe), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .pwr_ok_i(pwr), .tick_i(tick), .viol_o(viol)
  );
  task automatic print_verdict();
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    n_checks++;
    if (v !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, v);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ad;
    logic dd;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    ad = 1'b0;
    dd = 1'b0;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awr) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (!dd && wrdy) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (!bv);
    rs = bresp;
    bre <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    d = rdat;
    rs = rresp;
    rre <= 1'b0;
  endtask : axr
  task automatic st(input logic [31:0] e);
    axr(REG_STAT_OFS, s, r);
    chk("status", e, s);
  endtask : st
  task automatic pin(input logic w, input logic [10:0] a, input logic [7:0] d);
    int n;
    axw(REG_ADDR_OFS, {21'h0, a}, r);
    axw(REG_WDAT_OFS, {24'h0, d}, r);
    axw(REG_CMD_OFS, w ? 32'h2 : 32'h1, r);
    n = 0;
    do begin
      axr(REG_STAT_OFS, s, r);
      n++;
    end while (!s[ST_DONE_BIT] && n < 30);
    chk("pin done", 32'h1, {31'h0, s[ST_DONE_BIT]});
    axr(REG_RDAT_OFS, s, r);
    q = s[7:0];
    axw(REG_STAT_OFS, 32'h2, r);
  endtask : pin
  task automatic tk();
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
  endtask : tk
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (oe_h && dev_oe) begin
      fails++;
      $display("FAIL byte lines driven by both sides expected 0 seen 1");
    end
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    {rst_n, awv, wv, bre, arv, rre, tick} = '0;
    pwr = 1'b1;
    {awa, ara, wd, ws} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    ws <= 4'hf;
    repeat (REC + 4) @(posedge clk);
    foreach (rows[i]) begin
      axw(rows[i].a, rows[i].w, r);
      chk("bresp", rows[i].r, r);
      axr(rows[i].a, s, r);
      chk("reg read", rows[i].e, s);
      chk("rresp", rows[i].r, r);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset pins", 20'hE001C, {ce_n, oe_n, we_n, oe_h, baddr, awr, wrdy, arr, bv, rv});
    rst_n <= 1'b1;
    axw(REG_CMD_OFS, 32'h1, r);
    st(RF | PW);
    chk("ce idle", 1, ce_n);
    axw(REG_STAT_OFS, RF, r);
    repeat (REC + 4) @(posedge clk);
    st(RY | PW);
    pin(1'b1, 11'h123, 8'h5a);
    pin(1'b0, 11'h123, 8'h00);
    chk("plain byte", 8'h5a, q);
    pin(1'b0, 11'h124, 8'h00);
    chk("stored byte", 8'h24, q);
    pin(1'b0, 11'h7f7, 8'h00);
    st(RY | PW);
    pin(1'b1, 11'h7fc, 8'h05);
    pin(1'b0, 11'h7fc, 8'h00);
    chk("clock byte", 8'h05, q);
    st(RY | PW | CA);
    pin(1'b1, 11'h7f8, 8'h80);
    pin(1'b1, 11'h7f9, 8'h59);
    pin(1'b1, 11'h7f8, 8'h00);
    tk();
    pin(1'b0, 11'h7f9, 8'h00);
    chk("seconds rollover", 8'h00, q);
    tk();
    pin(1'b1, 11'h7f8, 8'h40);
    tk();
    pin(1'b0, 11'h7f9, 8'h00);
    chk("held seconds", 8'h01, q);
    pin(1'b1, 11'h7f8, 8'h00);
    tk();
    pin(1'b0, 11'h7f9, 8'h00);
    chk("resumed seconds", 8'h03, q);
    axw(REG_ADDR_OFS, 32'h200, r);
    axw(REG_WDAT_OFS, 32'haa, r);
    axw(REG_CMD_OFS, 32'h2, r);
    repeat (5) @(posedge clk);
    chk("write strobes", 2'b00, {ce_n, we_n});
    pwr <= 1'b0;
    repeat (3) @(posedge clk);
    chk("abort strobes", 3'b111, {ce_n, we_n, ~oe_h});
    st(32'h0);
    axw(REG_CMD_OFS, 32'h1, r);
    st(RF);
    pwr <= 1'b1;
    axw(REG_CMD_OFS, 32'h1, r);
    chk("ce after rise", 1, ce_n);
    repeat (REC + 4) @(posedge clk);
    st(RF | RY | PW);
    axw(REG_STAT_OFS, RF, r);
    pin(1'b0, 11'h123, 8'h00);
    chk("byte after power", 8'h5a, q);
    pin(1'b0, 11'h200, 8'h00);
    chk("blocked byte", 8'h00, q);
    chk("access timing", 0, viol);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
